// ==== shared/srso_pkg.sv ====
// Shared constants for the system reset status and option registers.
package srso_pkg;
  // Register byte addresses on the register port.
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'h1800;
  localparam logic [15:0] ADDR_OPTION_ONE = 16'h1802;
  localparam logic [15:0] ADDR_OPTION_TWO = 16'h1803;

  // Reset cause register bit positions.
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_EXT_PIN = 6;
  localparam int BIT_WATCHDOG = 5;
  localparam int BIT_BAD_OPCODE = 4;
  localparam int BIT_BAD_ADDRESS = 3;
  localparam int BIT_PROG_WAKEUP = 2;
  localparam int BIT_LOW_VOLTAGE = 1;

  // Option one bit positions.
  localparam int BIT_WATCHDOG_ON = 7;
  localparam int BIT_WATCHDOG_CLK = 6;
  localparam int BIT_STOP_ALLOW = 5;
  localparam int BIT_RADIO_ON = 4;
  localparam int BIT_TEMP_ON = 3;
  localparam int BIT_TEMP_DIR = 2;
  localparam int BIT_DEBUG_PIN = 1;

  // Option two field positions.
  localparam int POS_TIMEOUT = 4;
  localparam int BIT_CH0_SOURCE = 3;
  localparam int BIT_CH0_DIVIDE = 2;
  localparam int POS_BUS_CLOCK = 0;

  // Reset values.
  localparam logic [7:0] RST_CAUSE_POWER = 8'h82;
  localparam logic [7:0] RST_OPTION_TWO = 8'h70;
  localparam logic RST_WATCHDOG_ON = 1'b1;
  localparam logic RST_RADIO_ON = 1'b0;
  localparam logic RST_DEBUG_PIN = 1'b1;

  // Timing and clock figures.
  localparam int SYS_RESET_CYCLES = 4;
  localparam int CH0_DIVIDE_RATIO = 8;
  localparam int BUS_FROM_HFO_DIVIDE = 2;
  localparam logic [13:0] HFO_TOP_KHZ = 14'h1F40;

  // Reset sequencer states.
  typedef enum logic {SRSO_RUN, SRSO_HOLD} srso_state_e;
endpackage

// ==== rtl/srso_reset_seq.sv ====
// Reset sequencer: latches the cause vector and holds the system reset.
`timescale 1ns/1ns
module srso_reset_seq #(
  parameter int PULSE_CYCLES = srso_pkg::SYS_RESET_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] req_i,
  output logic [7:0] cause_o,
  output logic sys_reset_o
);
  import srso_pkg::*;

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  if (PULSE_CYCLES < 1) begin : g_bad_len
    $error("srso_reset_seq needs at least one reset cycle");
  end

  srso_state_e state;
  logic [CW-1:0] hold_cnt;

  // Requests raised while the reset is held are dropped; the core is halted then.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SRSO_RUN;
      hold_cnt <= '0;
      cause_o <= RST_CAUSE_POWER;
    end else begin
      case (state)
        SRSO_RUN: begin
          if (|req_i) begin
            state <= SRSO_HOLD;
            hold_cnt <= CW'(PULSE_CYCLES - 1);
            cause_o <= req_i;
          end
        end
        SRSO_HOLD: begin
          if (hold_cnt == '0) begin
            state <= SRSO_RUN;
          end else begin
            hold_cnt <= hold_cnt - CW'(1);
          end
        end
        default: state <= SRSO_RUN;
      endcase
    end
  end

  assign sys_reset_o = (state == SRSO_HOLD);
endmodule

// ==== rtl/srso_clock_route.sv ====
// Timer channel 0 clock routing, radio data clock divider and bus rate report.
`timescale 1ns/1ns
module srso_clock_route #(
  parameter int DIV_RATIO = srso_pkg::CH0_DIVIDE_RATIO
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ch0_source_i,
  input wire logic ch0_divide_i,
  input wire logic [1:0] bus_select_i,
  input wire logic port_a_pin_two_i,
  input wire logic low_freq_oscillator_i,
  input wire logic radio_data_clk_i,
  output logic timer_ch0_clk_o,
  output logic radio_data_clk_div_o,
  output logic [13:0] hfo_khz_o,
  output logic [13:0] bus_khz_o
);
  import srso_pkg::*;

  localparam int HALF = DIV_RATIO / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

  if (DIV_RATIO < 4 || (DIV_RATIO & (DIV_RATIO - 1)) != 0) begin : g_bad_div
    $error("srso_clock_route needs a power of two divide ratio of 4 or more");
  end

  logic [2:0] pin_raw;
  logic [2:0] pin_stable;
  logic rdx_last;
  logic [CW-1:0] div_cnt;
  logic div_clk;

  assign pin_raw = {radio_data_clk_i, low_freq_oscillator_i, port_a_pin_two_i};

  // Three-stage synchronisers; a change counts once stages two and three agree.
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic s1, s2, s3;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        pin_stable[i] <= 1'b0;
      end else begin
        s1 <= pin_raw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          pin_stable[i] <= s3;
        end
      end
    end
  end

  // Divider toggles every HALF rising edges of the sampled radio data clock.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdx_last <= 1'b0;
      div_cnt <= '0;
      div_clk <= 1'b0;
    end else begin
      rdx_last <= pin_stable[2];
      if (pin_stable[2] && !rdx_last) begin
        if (div_cnt == CW'(HALF - 1)) begin
          div_cnt <= '0;
          div_clk <= ~div_clk;
        end else begin
          div_cnt <= div_cnt + CW'(1);
        end
      end
    end
  end

  // Registered outputs; the bus always runs at the oscillator rate over two.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      timer_ch0_clk_o <= 1'b0;
      radio_data_clk_div_o <= 1'b0;
      hfo_khz_o <= HFO_TOP_KHZ;
      bus_khz_o <= 14'(HFO_TOP_KHZ / BUS_FROM_HFO_DIVIDE);
    end else begin
      timer_ch0_clk_o <= ch0_source_i ? pin_stable[1] : pin_stable[0];
      radio_data_clk_div_o <= ch0_divide_i ? div_clk : pin_stable[2];
      hfo_khz_o <= HFO_TOP_KHZ >> bus_select_i;
      bus_khz_o <= 14'((HFO_TOP_KHZ >> bus_select_i) / BUS_FROM_HFO_DIVIDE);
    end
  end
endmodule

// ==== rtl/srso_top.sv ====
// System reset cause recording, write-once options and option register bank.
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
// Behaviour
// - Illegal or unimplemented opcode reset sets cause bit 4, otherwise clears it.
// - Stop instruction while stop is not allowed causes an illegal-opcode reset.
// - Background instruction while debug mode is not allowed is an illegal opcode.
// - Access to unimplemented address resets and sets cause bit 3.
// - Wake-up reset in run, wait or shallow stop sets cause bit 2.
// - Low-voltage trip resets only when both low-voltage enables are set.
// - Low-voltage trip and power-on both set cause bit 1.
// - Bit 0 of the reset cause register reads zero.
// - Watchdog enable bit 7 is set by reset and accepts the first write only.
// - Watchdog clock select bit 6 cleared by reset, first write only.
// - Stop allow bit 5 cleared by reset, first write only.
// - Radio enable bit 4 writable anytime, initialised only at power-up.
// - Temperature restart enable bit 3, cleared by reset.
// - Temperature restart direction bit 2, cleared by reset, 1 means high.
// - Debug pin enable bit 1 selects debug pin or output-only GPIO.
// - Bit 0 of option one always reads one.
// - Bit 7 of option two always reads zero.
// - Watchdog timeout bits 6:4 reset to longest, written once.
// - Timer channel 0 clock comes from port pin or low-frequency oscillator.
// - Radio data clock for timer channel 0 divided by 1 or 8.
// - Bus clock select 1:0 gives 4, 2, 1, 0.5 MHz; reset clears; writable anytime.
// - Bus clock is always oscillator output divided by two.
// - Writing the reset cause address restarts the watchdog, contents unchanged.
// - Other resets set flags of active sources and clear inactive ones.
module srso_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic bad_opcode_i,
  input wire logic stop_instr_i,
  input wire logic background_instr_i,
  input wire logic debug_mode_allow_i,
  input wire logic bad_address_i,
  input wire logic prog_wakeup_i,
  input wire logic deep_stop_i,
  input wire logic ext_pin_reset_i,
  input wire logic watchdog_timeout_i,
  input wire logic low_voltage_reset_on_i,
  input wire logic low_voltage_stop_on_i,
  input wire logic low_voltage_trip_i,
  output logic sys_reset_o,
  output logic stop_enter_o,
  output logic bdm_enter_o,
  output logic watchdog_restart_o,
  output logic watchdog_on_o,
  output logic watchdog_clock_select_o,
  output logic [2:0] watchdog_timeout_select_o,
  output logic stop_instr_allow_o,
  output logic radio_on_o,
  output logic temp_restart_on_o,
  output logic temp_restart_direction_o,
  output logic debug_pin_on_o,
  input wire logic debug_pin_i,
  output logic debug_pin_o,
  output logic debug_pin_oe_o,
  input wire logic debug_out_i,
  input wire logic debug_oe_i,
  output logic debug_in_o,
  input wire logic gpio_out_i,
  input wire logic port_a_pin_two_i,
  input wire logic low_freq_oscillator_i,
  input wire logic radio_data_clk_i,
  output logic timer_ch0_clk_o,
  output logic radio_data_clk_div_o,
  output logic [13:0] hfo_khz_o,
  output logic [13:0] bus_khz_o
);
  import srso_pkg::*;

  logic [7:0] cause;
  logic [7:0] req;
  logic bad_op_req;
  logic low_voltage_req;
  logic wr_cause;
  logic wr_opt1;
  logic wr_opt2;
  logic lock_opt1;
  logic lock_timeout;
  logic timer_ch0_clock_source;
  logic timer_ch0_clock_divider;
  logic [1:0] bus_clock_select;
  logic [7:0] opt1_view;
  logic [7:0] opt2_view;
  logic [7:0] next_rdata;
  logic [1:0] pin_raw;
  logic [1:0] pin_stable;

  // Option writes are refused while the system reset is held, as the core is halted; cause writes are not.
  assign wr_cause = reg_wr_i && (reg_addr_i == ADDR_RESET_CAUSE);
  assign wr_opt1 = reg_wr_i && (reg_addr_i == ADDR_OPTION_ONE) && !sys_reset_o;
  assign wr_opt2 = reg_wr_i && (reg_addr_i == ADDR_OPTION_TWO) && !sys_reset_o;

  // The trip comparator and debug pin are asynchronous to the bus clock.
  assign pin_raw = {debug_pin_i, low_voltage_trip_i};

  // Three-stage synchronisers; a change counts once stages two and three agree.
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1, s2, s3;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        pin_stable[i] <= 1'b0;
      end else begin
        s1 <= pin_raw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          pin_stable[i] <= s3;
        end
      end
    end
  end

  // Illegal opcode sources: the core's own decode plus disallowed stop and background.
  assign bad_op_req = bad_opcode_i
    || (stop_instr_i && !stop_instr_allow_o)
    || (background_instr_i && !debug_mode_allow_i);

  // Low-voltage reset needs both enables, so a stop-time trip is ignored otherwise.
  assign low_voltage_req = pin_stable[0] && low_voltage_reset_on_i
    && low_voltage_stop_on_i;

  // A low-voltage reset looks like power-on; other causes are reported together.
  always_comb begin
    req = 8'h00;
    if (low_voltage_req) begin
      req = RST_CAUSE_POWER;
    end else begin
      req[BIT_EXT_PIN] = ext_pin_reset_i;
      req[BIT_WATCHDOG] = watchdog_timeout_i && watchdog_on_o;
      req[BIT_BAD_OPCODE] = bad_op_req;
      req[BIT_BAD_ADDRESS] = bad_address_i;
      req[BIT_PROG_WAKEUP] = prog_wakeup_i && !deep_stop_i;
    end
  end

  // Each reset replaces the whole cause vector, clearing inactive sources.
  srso_reset_seq #(
    .PULSE_CYCLES(SYS_RESET_CYCLES)
  ) u_reset_seq (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .req_i(req),
    .cause_o(cause),
    .sys_reset_o(sys_reset_o)
  );

  // Allowed stop and background instructions are passed on one cycle later, while no reset is held.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stop_enter_o <= 1'b0;
      bdm_enter_o <= 1'b0;
    end else begin
      stop_enter_o <= stop_instr_i && stop_instr_allow_o && !sys_reset_o;
      bdm_enter_o <= background_instr_i && debug_mode_allow_i && !sys_reset_o;
    end
  end

  // Any write to the cause address kicks the watchdog; the causes stay as they are.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_restart_o <= 1'b0;
    end else begin
      watchdog_restart_o <= wr_cause;
    end
  end

  // Write-once option one fields share a lock taken by the first write.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_on_o <= RST_WATCHDOG_ON;
      watchdog_clock_select_o <= 1'b0;
      stop_instr_allow_o <= 1'b0;
      lock_opt1 <= 1'b0;
    end else if (sys_reset_o) begin
      watchdog_on_o <= RST_WATCHDOG_ON;
      watchdog_clock_select_o <= 1'b0;
      stop_instr_allow_o <= 1'b0;
      lock_opt1 <= 1'b0;
    end else if (wr_opt1 && !lock_opt1) begin
      watchdog_on_o <= reg_wdata_i[BIT_WATCHDOG_ON];
      watchdog_clock_select_o <= reg_wdata_i[BIT_WATCHDOG_CLK];
      stop_instr_allow_o <= reg_wdata_i[BIT_STOP_ALLOW];
      lock_opt1 <= 1'b1;
    end
  end

  // The radio enable survives every system reset; only power-on clears it.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      radio_on_o <= RST_RADIO_ON;
    end else if (wr_opt1) begin
      radio_on_o <= reg_wdata_i[BIT_RADIO_ON];
    end
  end

  // Freely writable option one fields, returned to defaults by any reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      temp_restart_on_o <= 1'b0;
      temp_restart_direction_o <= 1'b0;
      debug_pin_on_o <= RST_DEBUG_PIN;
    end else if (sys_reset_o) begin
      temp_restart_on_o <= 1'b0;
      temp_restart_direction_o <= 1'b0;
      debug_pin_on_o <= RST_DEBUG_PIN;
    end else if (wr_opt1) begin
      temp_restart_on_o <= reg_wdata_i[BIT_TEMP_ON];
      temp_restart_direction_o <= reg_wdata_i[BIT_TEMP_DIR];
      debug_pin_on_o <= reg_wdata_i[BIT_DEBUG_PIN];
    end
  end

  // Timeout select is write-once; the clock fields may be rewritten at any time.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_timeout_select_o <= RST_OPTION_TWO[POS_TIMEOUT +: 3];
      lock_timeout <= 1'b0;
    end else if (sys_reset_o) begin
      watchdog_timeout_select_o <= RST_OPTION_TWO[POS_TIMEOUT +: 3];
      lock_timeout <= 1'b0;
    end else if (wr_opt2 && !lock_timeout) begin
      watchdog_timeout_select_o <= reg_wdata_i[POS_TIMEOUT +: 3];
      lock_timeout <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      timer_ch0_clock_source <= RST_OPTION_TWO[BIT_CH0_SOURCE];
      timer_ch0_clock_divider <= RST_OPTION_TWO[BIT_CH0_DIVIDE];
      bus_clock_select <= RST_OPTION_TWO[POS_BUS_CLOCK +: 2];
    end else if (sys_reset_o) begin
      timer_ch0_clock_source <= RST_OPTION_TWO[BIT_CH0_SOURCE];
      timer_ch0_clock_divider <= RST_OPTION_TWO[BIT_CH0_DIVIDE];
      bus_clock_select <= RST_OPTION_TWO[POS_BUS_CLOCK +: 2];
    end else if (wr_opt2) begin
      timer_ch0_clock_source <= reg_wdata_i[BIT_CH0_SOURCE];
      timer_ch0_clock_divider <= reg_wdata_i[BIT_CH0_DIVIDE];
      bus_clock_select <= reg_wdata_i[POS_BUS_CLOCK +: 2];
    end
  end

  // Shared pin: debug function when enabled, otherwise always-driven output GPIO.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      debug_pin_o <= 1'b0;
      debug_pin_oe_o <= 1'b0;
      debug_in_o <= 1'b0;
    end else if (debug_pin_on_o) begin
      debug_pin_o <= debug_out_i;
      debug_pin_oe_o <= debug_oe_i;
      debug_in_o <= pin_stable[1];
    end else begin
      debug_pin_o <= gpio_out_i;
      debug_pin_oe_o <= 1'b1;
      debug_in_o <= 1'b0;
    end
  end

  srso_clock_route #(
    .DIV_RATIO(CH0_DIVIDE_RATIO)
  ) u_clock_route (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ch0_source_i(timer_ch0_clock_source),
    .ch0_divide_i(timer_ch0_clock_divider),
    .bus_select_i(bus_clock_select),
    .port_a_pin_two_i(port_a_pin_two_i),
    .low_freq_oscillator_i(low_freq_oscillator_i),
    .radio_data_clk_i(radio_data_clk_i),
    .timer_ch0_clk_o(timer_ch0_clk_o),
    .radio_data_clk_div_o(radio_data_clk_div_o),
    .hfo_khz_o(hfo_khz_o),
    .bus_khz_o(bus_khz_o)
  );

  // Read views with the fixed reserved bits.
  assign opt1_view = {watchdog_on_o, watchdog_clock_select_o, stop_instr_allow_o,
    radio_on_o, temp_restart_on_o, temp_restart_direction_o, debug_pin_on_o,
    1'b1};
  assign opt2_view = {1'b0, watchdog_timeout_select_o, timer_ch0_clock_source,
    timer_ch0_clock_divider, bus_clock_select};

  // Address decode for reads; unmapped addresses read zero.
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr_i == ADDR_RESET_CAUSE) begin
      next_rdata = {cause[7:1], 1'b0};
    end else if (reg_addr_i == ADDR_OPTION_ONE) begin
      next_rdata = opt1_view;
    end else if (reg_addr_i == ADDR_OPTION_TWO) begin
      next_rdata = opt2_view;
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_cause_bit0: assert property (
    reg_rd_i && reg_addr_i == ADDR_RESET_CAUSE |=> reg_rdata_o[0] == 1'b0)
    else $error("reset cause bit 0 read as one");
  a_opt1_reserved: assert property (
    reg_rd_i && reg_addr_i == ADDR_OPTION_ONE |=> reg_rdata_o[0] == 1'b1)
    else $error("option one bit 0 did not read one");
  a_opt2_unused: assert property (
    reg_rd_i && reg_addr_i == ADDR_OPTION_TWO |=> reg_rdata_o[7] == 1'b0)
    else $error("option two bit 7 did not read zero");
  a_watchdog_kick: assert property (
    wr_cause && !sys_reset_o && req == 8'h00 |=> watchdog_restart_o && $stable(cause))
    else $error("cause write did not kick watchdog or changed causes");
  a_stop_illegal: assert property (
    stop_instr_i && !stop_instr_allow_o && !sys_reset_o && !low_voltage_req
    |=> sys_reset_o && cause[BIT_BAD_OPCODE] && !stop_enter_o)
    else $error("disallowed stop did not give illegal opcode reset");
  a_background_instr_illegal: assert property (
    background_instr_i && !debug_mode_allow_i && !sys_reset_o && !low_voltage_req
    |=> sys_reset_o && cause[BIT_BAD_OPCODE])
    else $error("disallowed background did not give illegal opcode reset");
  a_bad_address: assert property (
    bad_address_i && !sys_reset_o && !low_voltage_req |=> cause[BIT_BAD_ADDRESS])
    else $error("illegal address cause not recorded");
  a_wakeup_cause: assert property (
    prog_wakeup_i && !deep_stop_i && !sys_reset_o && !low_voltage_req
    |=> cause[BIT_PROG_WAKEUP])
    else $error("wake-up cause not recorded");
  a_low_voltage: assert property (
    low_voltage_req && !sys_reset_o |=> cause == RST_CAUSE_POWER)
    else $error("low-voltage reset cause wrong");
  a_cause_clears: assert property (
    req == 8'h08 && !sys_reset_o |=> cause == 8'h08)
    else $error("inactive cause flags not cleared");
  a_reset_hold: assert property (
    $rose(sys_reset_o) |-> sys_reset_o [*4] ##1 !sys_reset_o)
    else $error("system reset not held for four cycles");
  a_wonce_lock: assert property (
    wr_opt1 && lock_opt1 |=> $stable(watchdog_on_o) && $stable(stop_instr_allow_o))
    else $error("locked write-once field changed");
  a_timeout_lock: assert property (
    wr_opt2 && lock_timeout |=> $stable(watchdog_timeout_select_o))
    else $error("locked timeout select changed");
  a_radio_keep: assert property (
    sys_reset_o && !wr_opt1 |=> $stable(radio_on_o))
    else $error("radio enable disturbed by system reset");
  a_bus_anytime: assert property (
    wr_opt2 |=> bus_clock_select == $past(reg_wdata_i[1:0]))
    else $error("bus clock select write not taken");

  c_low_voltage: cover property (low_voltage_req && !sys_reset_o);
  c_stop_illegal: cover property (stop_instr_i && !stop_instr_allow_o && !sys_reset_o);
  c_locked_write: cover property (wr_opt1 && lock_opt1);
  c_cause_kick: cover property (wr_cause ##1 reg_rd_i);
endmodule

// ==== test/test_srso_top.sv ====
// Self-checking bench for the system reset status and option register bank.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: got %h want %h", $time, a, b); end end
module test_srso_top;
  import srso_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rdq = 1'b0, lv_re = 1'b0, lv_se = 1'b0, lv_trip = 1'b0;
  logic dbg_allow = 1'b1, deep = 1'b0, ent = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [3:0] misc = 4'h0;
  logic [7:0] rdata, rd, d1, d2, e1, e2;
  logic sys_reset, wd_restart, wd_on, radio, stop_enter, bdm_enter, pin_oe;
  logic [13:0] high_freq_oscillator, bus;
  logic [2:0] tsel;
  logic t0clk, t0_last = 1'b0;
  int n_tog = 0;
  logic [31:0] seed = 32'h0000_0026;
  int n_fail = 0, comparisons = 0;

  // Clock and a free-running count that wiggles the pin and clock inputs.
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) misc <= misc + 4'h1;

  srso_top u_srso_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rdq), .reg_rdata_o(rdata),
    .bad_opcode_i(ev[0]), .stop_instr_i(ev[1]), .background_instr_i(ev[2]),
    .debug_mode_allow_i(dbg_allow), .bad_address_i(ev[3]), .prog_wakeup_i(ev[4]),
    .deep_stop_i(deep), .ext_pin_reset_i(ev[5]), .watchdog_timeout_i(ev[6]),
    .low_voltage_reset_on_i(lv_re), .low_voltage_stop_on_i(lv_se),
    .low_voltage_trip_i(lv_trip), .sys_reset_o(sys_reset), .stop_enter_o(stop_enter),
    .bdm_enter_o(bdm_enter), .watchdog_restart_o(wd_restart), .watchdog_on_o(wd_on),
    .watchdog_clock_select_o(), .watchdog_timeout_select_o(tsel), .stop_instr_allow_o(),
    .radio_on_o(radio), .temp_restart_on_o(), .temp_restart_direction_o(),
    .debug_pin_on_o(), .debug_pin_i(misc[0]), .debug_pin_o(), .debug_pin_oe_o(pin_oe),
    .debug_out_i(misc[1]), .debug_oe_i(misc[2]), .debug_in_o(), .gpio_out_i(misc[3]),
    .port_a_pin_two_i(misc[1]), .low_freq_oscillator_i(misc[2]),
    .radio_data_clk_i(misc[0]), .timer_ch0_clk_o(t0clk), .radio_data_clk_div_o(),
    .hfo_khz_o(high_freq_oscillator), .bus_khz_o(bus));

  // Xorshift source; a fixed start keeps every run identical.
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Cause vector expected for each event input, in the order of ev.
  function automatic logic [7:0] cause_of(input int i);
    case (i)
      3: return 8'h08;
      4: return 8'h04;
      5: return 8'h40;
      6: return 8'h20;
      default: return 8'h10;
    endcase
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rdq <= 1'b1;
    @(posedge clk_sys_i);
    rdq <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Pulses one event for a cycle, then checks whether a system reset follows.
  task automatic fire(input int i, input logic [7:0] want, input logic hit);
    logic seen;
    int c;
    seen = 1'b0;
    c = 0;
    @(posedge clk_sys_i);
    ev <= 7'h01 << i;
    lv_trip <= (i == 7);
    @(posedge clk_sys_i);
    ev <= 7'h00;
    // The trip must outlast the pin filter, but end before the reset does.
    if (i == 7) repeat (2) @(posedge clk_sys_i);
    lv_trip <= 1'b0;
    for (int k = 0; k < 12 && !seen; k++) begin
      #1;
      seen = (sys_reset === 1'b1);
      ent = ent | (stop_enter === 1'b1) | (bdm_enter === 1'b1);
      if (!seen) @(posedge clk_sys_i);
    end
    `CHK(seen, hit)
    if (seen !== hit) end_sim();
    while (sys_reset === 1'b1 && c < 12) begin
      @(posedge clk_sys_i);
      #1;
      c++;
    end
    if (hit) begin
      `CHK(c, SYS_RESET_CYCLES)
      if (c == 12) end_sim();
      rd_reg(ADDR_RESET_CAUSE, rd);
      `CHK(rd, want)
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd_reg(ADDR_RESET_CAUSE, rd);
    `CHK(rd, RST_CAUSE_POWER)
    rd_reg(ADDR_OPTION_ONE, rd);
    `CHK(rd, 8'h83)
    rd_reg(ADDR_OPTION_TWO, rd);
    `CHK(rd, RST_OPTION_TWO)
    rd_reg(16'h1801, rd);
    `CHK(rd, 8'h00)
    $display("test reset values done");
    // Write-once bits keep the first value; the others follow every write.
    d1 = rnd() | 8'h20;
    wr_reg(ADDR_OPTION_ONE, d1);
    rd_reg(ADDR_OPTION_ONE, rd);
    `CHK(rd, {d1[7:1], 1'b1})
    `CHK(wd_on, d1[7])
    d2 = rnd() & 8'hFD;
    wr_reg(ADDR_OPTION_ONE, d2);
    rd_reg(ADDR_OPTION_ONE, rd);
    `CHK(rd, {d1[7:5], d2[4:1], 1'b1})
    `CHK(radio, d2[4])
    `CHK(pin_oe, 1'b1)
    e1 = rnd();
    wr_reg(ADDR_OPTION_TWO, e1);
    e2 = rnd();
    wr_reg(ADDR_OPTION_TWO, e2);
    rd_reg(ADDR_OPTION_TWO, rd);
    `CHK(rd, {1'b0, e1[6:4], e2[3:0]})
    `CHK(tsel, e1[6:4])
    `CHK(bus, 14'h0FA0 >> e2[1:0])
    `CHK(high_freq_oscillator, 14'h1F40 >> e2[1:0])
    // The port pin input toggles twice as often as the slow oscillator input.
    t0_last = t0clk;
    for (int k = 0; k < 32; k++) begin
      @(posedge clk_sys_i);
      #1;
      if (t0clk !== t0_last) n_tog++;
      t0_last = t0clk;
    end
    `CHK(n_tog > 12, !e2[3])
    $display("test option writes done");
    wr_reg(ADDR_RESET_CAUSE, rnd());
    #1;
    `CHK(wd_restart, 1'b1)
    rd_reg(ADDR_RESET_CAUSE, rd);
    `CHK(rd, RST_CAUSE_POWER)
    // Allowed stop and background instructions must not reset.
    fire(1, 8'h00, 1'b0);
    `CHK(ent, 1'b1)
    ent = 1'b0;
    fire(2, 8'h00, 1'b0);
    `CHK(ent, 1'b1)
    dbg_allow <= 1'b0;
    $display("test watchdog restart done");
    // The first reset clears stop allow, so the stop event then counts as illegal.
    for (int i = 0; i < 7; i++) fire(i, cause_of(i), 1'b1);
    rd_reg(ADDR_OPTION_ONE, rd);
    `CHK(rd, 8'h83 | {3'b000, d2[4], 4'h0})
    rd_reg(ADDR_OPTION_TWO, rd);
    `CHK(rd, RST_OPTION_TWO)
    wr_reg(ADDR_OPTION_ONE, 8'h00);
    rd_reg(ADDR_OPTION_ONE, rd);
    `CHK(rd, 8'h01)
    $display("test reset causes done");
    lv_re <= 1'b1;
    fire(7, 8'h00, 1'b0);
    lv_se <= 1'b1;
    fire(7, RST_CAUSE_POWER, 1'b1);
    $display("test low voltage done");
    end_sim();
  end
endmodule
